// ==== shared/dps_cfg.svh ====
// Purpose: timing counts, thresholds and factory values of the supervisor
// Assumes: 25 MHz system clock; currents in 0.1 A, voltages in 0.1 V
// Notes: long counts reach the core as parameters so they can be shortened
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH

`define DPS_CLK_HZ        25000000
`define DPS_TICK_MS       100
`define DPS_TICK_CYC      ((`DPS_CLK_HZ / 1000) * `DPS_TICK_MS)
`define DPS_BLINK_HZ      2
`define DPS_BLINK_HALF_MS (1000 / (2 * `DPS_BLINK_HZ))
`define DPS_BLINK_CYC     ((`DPS_CLK_HZ / 1000) * `DPS_BLINK_HALF_MS)
`define DPS_LAMP_STEP_MS  200
`define DPS_LAMP_STEP_T   (`DPS_LAMP_STEP_MS / `DPS_TICK_MS)

`define DPS_REARM_S       20
`define DPS_REARM_T       (`DPS_REARM_S * 1000 / `DPS_TICK_MS)
`define DPS_EN_HOLD_S     5
`define DPS_EN_HOLD_T     (`DPS_EN_HOLD_S * 1000 / `DPS_TICK_MS)
`define DPS_EDIT_HOLD_S   3
`define DPS_EDIT_HOLD_T   (`DPS_EDIT_HOLD_S * 1000 / `DPS_TICK_MS)
`define DPS_AUTO_MAX      2'h3

`define DPS_WARN_PCT      90
`define DPS_WARN_CLR      8'h02
`define DPS_DEF_RATING    3'h1
`define DPS_UV_THR_MIN    9'h06e
`define DPS_UV_THR_MAX    9'h122
`define DPS_UV_THR_DEF    9'h06e
`define DPS_UV_DLY_MIN    7'h0a
`define DPS_UV_DLY_MAX    7'h64
`define DPS_UV_DLY_DEF    7'h0a

`endif

// ==== shared/dps_pkg.sv ====
// Purpose: types shared by the protection supervisor
// Assumes: two channels, four ratings each
// Notes: ratings carry codes 1..4 for 2, 4, 6 and 10 A
package dps_pkg;

    typedef enum logic [1:0] {
        MD_LAMP = 2'h0,
        MD_RUN  = 2'h1,
        MD_EDIT = 2'h3,
        MD_EXIT = 2'h2
    } dps_mode_t;

    typedef struct packed {
        logic [8:0] voltage;
        logic [7:0] current;
    } dps_meas_t;

    typedef struct packed {
        logic       autoRearmEn;
        logic       uvloEn;
        logic [8:0] uvloThr;
        logic [6:0] uvloDelay;
    } dps_chcfg_t;

    typedef struct packed {
        logic       enabled;
        logic       active;
        logic       tripped;
        logic       overTemp;
        logic       failure;
        logic       uvLock;
        logic       warn;
        logic [2:0] rating;
    } dps_chstat_t;

    typedef struct packed {
        logic       en;
        logic [2:0] rating;
        logic       tripped;
        logic [7:0] tripAge;
        logic [1:0] autoCnt;
        logic       autoSusp;
        logic [6:0] uvCnt;
        logic       uvLock;
        logic       warn;
        logic       fail;
        logic [5:0] keyHold;
        logic       keyUsed;
    } dps_chan_t;

    typedef struct packed {
        dps_chan_t [1:0] ch;
        dps_mode_t       mode;
        logic [2:0]      lampIdx;
        logic [1:0]      lampCnt;
        logic [23:0]     tickCnt;
        logic [23:0]     blinkCnt;
        logic            blinkPh;
        logic [5:0]      bothHold;
        logic            bothUsed;
        logic [5:0]      sync1;
        logic [5:0]      sync2;
        logic [5:0]      prev;
        logic [7:0]      led;
        logic [1:0]      chanOn;
        logic            good;
    } dps_state_t;

endpackage : dps_pkg

// ==== core/dps_supervisor.sv ====
// Purpose: supervisory logic of a two-channel DC output protector
// Assumes: trip, current and voltage inputs come from logic on ref_clk
// Notes: keys, overtemperature, failure and remote input are pins
// Contract
// R1 - warn when channel current exceeds ninety percent of its rating
// R2 - warning blinks the rating LED at 2 Hz and sets warning status
// R3 - warning clears only when current falls below 0.2 A
// R4 - automatic rearm re-enables a tripped channel no sooner than 20 s
// R5 - three trips after automatic rearms suspend automatic rearm
// R6 - undervoltage longer than the lockout delay switches the channel off
// R7 - overtemperature disables the output channels
// R8 - channels come back on their own when overtemperature clears
// R9 - hardware failure disables only the affected channel
// R10 - failure blinks that channel's LEDs and sets its failure status
// R11 - eight LEDs and two keys, one key per channel
// R12 - enabled channel lights its rating LED; disabled channel stays dark; code still blinks a disabled channel that is failed or tripped
// R13 - five second key hold toggles channel enable
// R14 - both keys held three seconds enter rating edit, LEDs blink
// R15 - in edit mode a short press steps the channel rating
// R16 - both keys held again leave edit dark until keys released
// R17 - tripped channel blinks all its LEDs until rearmed
// R18 - key rearm only after 20 s since trip, earlier presses ignored
// R19 - after rearm the trip blink stops and rating LED lights
// R20 - power-up lamp check lights each LED in turn, then states
// R21 - factory defaults: 2 A rating, channels disabled, sane lockout values
// R22 - status good drops on inhibit, open, trip, heat, failure, lockout, warn
// R23 - lockout threshold 11 to 29 V, delay 1 to 10 s, 0.1 steps
// R24 - ratings coded 1 to 4 for 2, 4, 6, 10 A, edit cycles them
// R25 - lockout timer restarts when voltage recovers before expiry
// R26 - auto rearm count clears after stable run or manual rearm
`timescale 1ns/100ps
`default_nettype none
`include "dps_cfg.svh"

module dps_supervisor #(
    parameter int TICK_CYC  = `DPS_TICK_CYC,
    parameter int BLINK_CYC = `DPS_BLINK_CYC
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic [1:0]                keyIn,
    input  wire logic                      overTempIn,
    input  wire logic [1:0]                hwFailIn,
    input  wire logic                      remoteIn,
    input  wire logic [1:0]                tripIn,
    input  wire dps_pkg::dps_meas_t  [1:0] meas,
    input  wire dps_pkg::dps_chcfg_t [1:0] chCfg,
    input  wire logic                      inputInhibit,
    input  wire logic                      inhibitPolHigh,
    input  wire logic                      ratingEditEn,
    output logic [1:0]                     chanOn,
    output logic [7:0]                     led,
    output dps_pkg::dps_chstat_t [1:0]     chStat,
    output logic                           statusGood
);
    import dps_pkg::*;

    localparam logic [7:0] REARM_T = 8'(`DPS_REARM_T);
    localparam logic [5:0] EN_T    = 6'(`DPS_EN_HOLD_T);
    localparam logic [5:0] EDIT_T  = 6'(`DPS_EDIT_HOLD_T);
    localparam logic [1:0] LAMP_T  = 2'(`DPS_LAMP_STEP_T - 1);

    dps_state_t st_r;
    dps_state_t st_nxt;

    function automatic logic [7:0] warnThr(input logic [2:0] code);
        int tenthA;
        case (code)
            3'h2:    tenthA = 40;
            3'h3:    tenthA = 60;
            3'h4:    tenthA = 100;
            default: tenthA = 20;
        endcase
        return 8'(tenthA * `DPS_WARN_PCT / 100);
    endfunction : warnThr

    function automatic logic [2:0] nextRating(input logic [2:0] code);
        return (code >= 3'h4) ? 3'h1 : 3'(code + 3'h1);
    endfunction : nextRating

    function automatic logic [3:0] ratingLed(input logic [2:0] code);
        return 4'h1 << 2'(code - 3'h1);
    endfunction : ratingLed

    logic       tick;
    logic [1:0] key;
    logic [1:0] keyRise;
    logic [1:0] keyFall;
    logic       overTemp;
    logic       inhibit;
    logic       remRearm;
    logic       both;
    logic       bothFire;

    always_comb begin
        dps_chan_t  ch;
        logic [8:0] thr;
        logic [6:0] dly;
        logic       canRearm;
        logic [3:0] chLed;
        ch       = st_r.ch[0];
        thr      = `DPS_UV_THR_DEF;
        dly      = `DPS_UV_DLY_DEF;
        canRearm = 1'b0;
        chLed    = 4'h0;
        st_nxt   = st_r;
        st_nxt.sync1 = {remoteIn, hwFailIn, overTempIn, keyIn};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev  = st_r.sync2;
        key      = st_r.sync2[1:0];
        keyRise  = key & ~st_r.prev[1:0];
        keyFall  = ~key & st_r.prev[1:0];
        overTemp = st_r.sync2[2];
        inhibit  = inputInhibit && (st_r.sync2[5] == inhibitPolHigh);
        remRearm = !inputInhibit && (st_r.sync2[5] != st_r.prev[5]);
        both     = &key;

        tick = (st_r.tickCnt == 24'(TICK_CYC - 1));
        st_nxt.tickCnt = tick ? 24'h0 : st_r.tickCnt + 24'h1;
        if (st_r.blinkCnt == 24'(BLINK_CYC - 1)) begin
            st_nxt.blinkCnt = 24'h0;
            st_nxt.blinkPh  = ~st_r.blinkPh;
        end else begin
            st_nxt.blinkCnt = st_r.blinkCnt + 24'h1;
        end

        // both-key hold timer
        bothFire = both && !st_r.bothUsed && (st_r.bothHold >= EDIT_T);
        if (!both) begin
            st_nxt.bothHold = 6'h0;
            st_nxt.bothUsed = 1'b0;
        end else if (bothFire) begin
            st_nxt.bothUsed = 1'b1;
        end else if (tick && !st_r.bothUsed) begin
            st_nxt.bothHold = st_r.bothHold + 6'h1;
        end

        case (st_r.mode)
            MD_LAMP: begin
                if (tick) begin
                    st_nxt.lampCnt = st_r.lampCnt + 2'h1;
                    if (st_r.lampCnt == LAMP_T) begin
                        st_nxt.lampCnt = 2'h0;
                        st_nxt.lampIdx = st_r.lampIdx + 3'h1;
                        if (st_r.lampIdx == 3'h7) begin
                            st_nxt.mode = MD_RUN; // R20
                        end
                    end
                end
            end
            MD_RUN: begin
                if (bothFire && ratingEditEn) begin
                    st_nxt.mode = MD_EDIT; // R14
                end
            end
            MD_EDIT: begin
                if (bothFire) begin
                    st_nxt.mode = MD_EXIT; // R16
                end
            end
            MD_EXIT: begin
                if (key == 2'h0) begin
                    st_nxt.mode = MD_RUN; // R16
                end
            end
            default: st_nxt.mode = MD_RUN;
        endcase

        for (int c = 0; c < 2; c++) begin
            ch = st_r.ch[c];
            if (tick && ch.tripAge < REARM_T) begin
                ch.tripAge = ch.tripAge + 8'h1;
            end
            if (!ch.tripped && st_r.ch[c].tripAge >= REARM_T) begin
                ch.autoCnt = 2'h0; // R26
            end
            if (st_r.sync2[3 + c]) begin
                ch.fail = 1'b1; // R9
            end
            if (meas[c].current > warnThr(st_r.ch[c].rating)) begin
                ch.warn = 1'b1; // R1
            end else if (meas[c].current < `DPS_WARN_CLR) begin
                ch.warn = 1'b0; // R3
            end

            // lockout settings outside range fall back to defaults
            if (chCfg[c].uvloThr >= `DPS_UV_THR_MIN && chCfg[c].uvloThr <= `DPS_UV_THR_MAX) begin
                thr = chCfg[c].uvloThr; // R23
            end else begin
                thr = `DPS_UV_THR_DEF;
            end
            if (chCfg[c].uvloDelay >= `DPS_UV_DLY_MIN
                && chCfg[c].uvloDelay <= `DPS_UV_DLY_MAX) begin
                dly = chCfg[c].uvloDelay; // R23
            end else begin
                dly = `DPS_UV_DLY_DEF;
            end
            if (!chCfg[c].uvloEn || meas[c].voltage >= thr) begin
                ch.uvCnt  = 7'h0; // R25
                ch.uvLock = 1'b0;
            end else begin
                if (tick && ch.uvCnt != 7'h7f) begin
                    ch.uvCnt = ch.uvCnt + 7'h1;
                end
                if (st_r.ch[c].uvCnt > dly) begin
                    ch.uvLock = 1'b1; // R6
                end
            end

            // single-key hold and short press
            if (!key[c]) begin
                ch.keyHold = 6'h0;
                ch.keyUsed = 1'b0;
            end else if (both) begin
                ch.keyUsed = 1'b1;
                ch.keyHold = 6'h0;
            end else if (st_r.mode == MD_RUN && !st_r.ch[c].keyUsed
                         && st_r.ch[c].keyHold >= EN_T) begin
                ch.en      = ~st_r.ch[c].en; // R13
                ch.keyUsed = 1'b1;
            end else if (tick && !st_r.ch[c].keyUsed) begin
                ch.keyHold = st_r.ch[c].keyHold + 6'h1;
            end
            if (st_r.mode == MD_EDIT && keyFall[c] && !st_r.ch[c].keyUsed) begin
                ch.rating = nextRating(st_r.ch[c].rating); // R15 R24
            end

            // rearm and trip
            canRearm = st_r.ch[c].tripped && st_r.ch[c].tripAge >= REARM_T; // R18
            if (canRearm && st_r.mode == MD_RUN && (keyRise[c] || remRearm)) begin
                ch.tripped  = 1'b0; // R19
                ch.tripAge  = 8'h0;
                ch.autoCnt  = 2'h0; // R26
                ch.autoSusp = 1'b0;
            end else if (canRearm && chCfg[c].autoRearmEn && !st_r.ch[c].autoSusp) begin
                ch.tripped = 1'b0; // R4
                ch.tripAge = 8'h0;
                if (st_r.ch[c].autoCnt != `DPS_AUTO_MAX) begin
                    ch.autoCnt = st_r.ch[c].autoCnt + 2'h1;
                end
            end
            if (tripIn[c] && st_r.chanOn[c]) begin
                ch.tripped = 1'b1;
                ch.tripAge = 8'h0;
                if (st_r.ch[c].autoCnt == `DPS_AUTO_MAX) begin
                    ch.autoSusp = 1'b1; // R5
                end
            end
            st_nxt.ch[c] = ch;
            st_nxt.chanOn[c] = ch.en && !ch.tripped && !overTemp // R7 R8
                               && !ch.fail && !ch.uvLock && !inhibit; // R9 R6

            // per-channel LED group
            if (ch.fail || ch.tripped) begin
                chLed = st_r.blinkPh ? 4'hf : 4'h0; // R10 R17
            end else if (!ch.en) begin
                chLed = 4'h0; // R12
            end else if (ch.warn) begin
                chLed = st_r.blinkPh ? ratingLed(ch.rating) : 4'h0; // R2
            end else begin
                chLed = ratingLed(ch.rating); // R12 R19
            end
            case (st_r.mode)
                MD_LAMP: st_nxt.led[4*c +: 4] = 4'h0;
                MD_EDIT: st_nxt.led[4*c +: 4] = st_r.blinkPh ? ratingLed(ch.rating) : 4'h0;
                MD_EXIT: st_nxt.led[4*c +: 4] = 4'h0;
                default: st_nxt.led[4*c +: 4] = chLed; // R11
            endcase
        end
        if (st_r.mode == MD_LAMP) begin
            st_nxt.led = 8'h01 << st_r.lampIdx; // R20
        end

        st_nxt.good = !(inhibit || !(st_nxt.ch[0].en && st_nxt.ch[1].en) // R22
                        || st_nxt.ch[0].tripped || st_nxt.ch[1].tripped || overTemp
                        || st_nxt.ch[0].fail || st_nxt.ch[1].fail
                        || st_nxt.ch[0].uvLock || st_nxt.ch[1].uvLock
                        || st_nxt.ch[0].warn || st_nxt.ch[1].warn);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.ch[0].rating <= `DPS_DEF_RATING; // R21
            st_r.ch[1].rating <= `DPS_DEF_RATING; // R21
        end else begin
            st_r <= st_nxt;
        end
    end

    assign chanOn     = st_r.chanOn;
    assign led        = st_r.led;
    assign statusGood = st_r.good;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            chStat[c].enabled  = st_r.ch[c].en;
            chStat[c].active   = st_r.chanOn[c];
            chStat[c].tripped  = st_r.ch[c].tripped;
            chStat[c].overTemp = st_r.sync2[2];
            chStat[c].failure  = st_r.ch[c].fail; // R10
            chStat[c].uvLock   = st_r.ch[c].uvLock;
            chStat[c].warn     = st_r.ch[c].warn; // R2
            chStat[c].rating   = st_r.ch[c].rating;
        end
    end

    default clocking dps_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_warn_rise: assert property ( // R1
        $rose(st_r.ch[0].warn) |-> $past(meas[0].current) > warnThr($past(st_r.ch[0].rating))
    ) else $error("warning raised below ninety percent");

    a_warn_hold: assert property ( // R3
        st_r.ch[0].warn && meas[0].current >= `DPS_WARN_CLR |=> st_r.ch[0].warn
    ) else $error("warning cleared above 0.2 A");

    a_rearm_wait: assert property ( // R18
        $fell(st_r.ch[1].tripped) |-> $past(st_r.ch[1].tripAge) >= REARM_T
    ) else $error("rearm before hold-off");

    a_auto_suspend: assert property ( // R5
        tripIn[0] && st_r.chanOn[0] && st_r.ch[0].autoCnt == 2'h3 |=> st_r.ch[0].autoSusp
    ) else $error("auto rearm not suspended");

    a_uvlo_delay: assert property ( // R6
        $rose(st_r.ch[1].uvLock) |-> $past(st_r.ch[1].uvCnt) > `DPS_UV_DLY_MIN
        && ($past(st_r.ch[1].uvCnt) > $past(chCfg[1].uvloDelay)
            || $past(chCfg[1].uvloDelay) > `DPS_UV_DLY_MAX)
    ) else $error("lockout before delay");

    a_heat_off: assert property ( // R7
        st_r.sync2[2] |=> chanOn == 2'h0
    ) else $error("channel on during overtemperature");

    a_fail_off: assert property ( // R9
        st_r.ch[1].fail |=> !chanOn[1]
    ) else $error("failed channel still on");

    a_dark_off: assert property ( // R12
        st_r.mode == MD_RUN && !st_nxt.ch[0].en && !st_nxt.ch[0].tripped
        && !st_nxt.ch[0].fail |=> led[3:0] == 4'h0
    ) else $error("disabled channel lit");

    a_good_low: assert property ( // R22
        st_r.ch[0].warn || st_r.ch[1].tripped |-> !statusGood
    ) else $error("status good while warning or tripped");

    a_hold_toggle: assert property ( // R13
        $changed(st_r.ch[0].en) |-> $past(st_r.ch[0].keyHold) >= EN_T
    ) else $error("enable toggled before full hold");

endmodule : dps_supervisor
`default_nettype wire

// ==== bench/dps_operator.sv ====
// Purpose: operator model pressing the two keys and driving the remote input
// Assumes: a key reads high while pressed; a released key is pulled low
// Notes: every change lands one small delay after a rising edge
`timescale 1ns/100ps
`default_nettype none

module dps_operator #(
    parameter int TICK_CYC = 10
) (
    input  wire logic       ref_clk,
    output var  logic [1:0] keyIn,
    output var  logic       remoteIn
);
    initial begin
        keyIn    = 2'h0;
        remoteIn = 1'b0;
    end

    // key level, long holds and both-key holds
    task automatic set_keys(input logic [1:0] keys);
        @(posedge ref_clk);
        #1 keyIn = keys;
    endtask : set_keys

    // short presses for rating steps and rearm
    task automatic tap(input logic [1:0] keys, input int n);
        repeat (n) begin
            set_keys(keys);
            repeat (2 * TICK_CYC) @(posedge ref_clk);
            set_keys(2'h0);
            repeat (2 * TICK_CYC) @(posedge ref_clk);
        end
    endtask : tap

    task automatic set_remote(input logic v);
        @(posedge ref_clk);
        #1 remoteIn = v;
    endtask : set_remote
endmodule : dps_operator
`default_nettype wire

// ==== bench/dps_supervisor_test.sv ====
// Purpose: self-checking bench of the protection supervisor
// Assumes: shortened tick of 10 cycles and blink half period of 4 cycles
// Notes: channel switch changes are checked against a queue of notes
`timescale 1ns/100ps
`default_nettype none

module dps_supervisor_test;
    import dps_pkg::*;
    localparam int TICK  = 10;
    localparam int BLINK = 4;

    logic              ref_clk;
    logic              rst_n;
    logic              overTempIn;
    logic              inputInhibit;
    logic              inhibitPolHigh;
    logic              ratingEditEn;
    logic              remoteIn;
    logic              statusGood;
    logic [1:0]        keyIn;
    logic [1:0]        hwFailIn;
    logic [1:0]        tripIn;
    logic [1:0]        chanOn;
    logic [1:0]        lastOn;
    logic [7:0]        led;
    logic [7:0]        diff;
    dps_meas_t [1:0]   meas;
    dps_chcfg_t [1:0]  chCfg;
    dps_chstat_t [1:0] chStat;
    logic [1:0]        onQ[$];
    int                bad_count;
    int                check_count;
    int                seed;
    int                i;

    dps_supervisor #(.TICK_CYC(TICK), .BLINK_CYC(BLINK)) u_dps_supervisor (
        .ref_clk(ref_clk), .rst_n(rst_n), .keyIn(keyIn), .overTempIn(overTempIn),
        .hwFailIn(hwFailIn), .remoteIn(remoteIn), .tripIn(tripIn), .meas(meas),
        .chCfg(chCfg), .inputInhibit(inputInhibit), .inhibitPolHigh(inhibitPolHigh),
        .ratingEditEn(ratingEditEn), .chanOn(chanOn), .led(led), .chStat(chStat),
        .statusGood(statusGood)
    );

    dps_operator #(.TICK_CYC(TICK)) u_dps_operator (
        .ref_clk(ref_clk), .keyIn(keyIn), .remoteIn(remoteIn)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic ticks(input int n);
        cyc(n * TICK);
    endtask : ticks

    task automatic blink_diff;
        diff = led;
        cyc(BLINK);
        diff = diff ^ led;
    endtask : blink_diff

    task automatic trip_pulse(input logic [1:0] m);
        tripIn = m;
        cyc(1);
        tripIn = 2'h0;
    endtask : trip_pulse

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // every change of the channel switches takes the oldest note
    always @(negedge ref_clk) begin
        if (rst_n === 1'b1 && chanOn !== lastOn) begin
            if (onQ.size() > 0)
                check(chanOn, onQ.pop_front());
            else
                check(chanOn, lastOn);
            lastOn = chanOn;
        end
    end

    initial begin
        cyc(60000);
        bad_count++;
        end_of_test();
    end

    initial begin
        seed = 20845;
        bad_count = 0;
        check_count = 0;
        lastOn = 2'h0;
        rst_n = 1'b0;
        tripIn = 2'h0;
        hwFailIn = 2'h0;
        overTempIn = 1'b0;
        inputInhibit = 1'b0;
        inhibitPolHigh = 1'b1;
        ratingEditEn = 1'b1;
        chCfg = '0;
        for (i = 0; i < 2; i++) begin
            chCfg[i].uvloThr = 9'h06e + 9'($unsigned($random(seed)) % 40);
            chCfg[i].uvloDelay = 7'h0a + 7'($unsigned($random(seed)) % 91);
            meas[i].voltage = 9'h096 + 9'($unsigned($random(seed)) % 100);
            meas[i].current = 8'($unsigned($random(seed)) % 16);
        end
        chCfg[0].uvloEn = 1'b1;
        cyc(6);
        check({chanOn, led, statusGood}, 11'h000);
        check(chStat, {10'h001, 10'h001});
        cyc(6);
        rst_n = 1'b1;
        for (i = 0; i < 8; i++) begin
            cyc(10);
            check(led, 8'h01 << i);
            cyc(10);
        end
        cyc(40);
        check({led, chanOn, statusGood}, 11'h000);
        check(chStat, {10'h001, 10'h001});
        // short hold refused, full holds toggle
        u_dps_operator.set_keys(2'h1);
        ticks(45);
        u_dps_operator.set_keys(2'h0);
        ticks(3);
        onQ.push_back(2'h1);
        u_dps_operator.set_keys(2'h1);
        ticks(53);
        onQ.push_back(2'h3);
        u_dps_operator.set_keys(2'h2);
        ticks(53);
        u_dps_operator.set_keys(2'h0);
        ticks(2);
        check({led, statusGood}, 9'h023);
        // load warning threshold and clearing
        meas[0].current = 8'h12;
        cyc(5);
        check(chStat[0].warn, 1'b0);
        meas[0].current = 8'h13;
        cyc(5);
        check({chStat[0].warn, statusGood}, 2'h2);
        blink_diff();
        check(diff, 8'h01);
        meas[0].current = 8'h02;
        cyc(5);
        check(chStat[0].warn, 1'b1);
        meas[0].current = 8'h01;
        cyc(5);
        check({chStat[0].warn, led}, 9'h011);
        // overtemperature off and back
        onQ.push_back(2'h0);
        overTempIn = 1'b1;
        cyc(8);
        check({chStat[0].overTemp, statusGood}, 2'h2);
        onQ.push_back(2'h3);
        overTempIn = 1'b0;
        cyc(8);
        // trip, early press ignored, late press rearms
        onQ.push_back(2'h2);
        trip_pulse(2'h1);
        ticks(2);
        blink_diff();
        check(diff, 8'h0f);
        ticks(48);
        u_dps_operator.tap(2'h1, 1);
        ticks(2);
        check(chStat[0].tripped, 1'b1);
        ticks(160);
        onQ.push_back(2'h3);
        u_dps_operator.tap(2'h1, 1);
        ticks(2);
        check({chStat[0].tripped, led}, 9'h011);
        // lockout with a recovery that restarts the delay
        chCfg[1].uvloEn = 1'b1;
        meas[1].voltage = 9'h064;
        ticks(8);
        meas[1].voltage = 9'h096;
        ticks(2);
        meas[1].voltage = 9'h064;
        ticks(int'(chCfg[1].uvloDelay) - 4);
        onQ.push_back(2'h1);
        ticks(8);
        check(chStat[1].uvLock, 1'b1);
        onQ.push_back(2'h3);
        meas[1].voltage = 9'h096;
        ticks(2);
        // three automatic rearms, then suspended; the first trips both
        chCfg[0].autoRearmEn = 1'b1;
        chCfg[1].autoRearmEn = 1'b1;
        for (i = 0; i < 4; i++) begin
            onQ.push_back((i == 0) ? 2'h0 : 2'h2);
            trip_pulse((i == 0) ? 2'h3 : 2'h1);
            ticks(190);
            if (i < 3) begin
                onQ.push_back(2'h3);
                ticks(15);
            end
        end
        ticks(25);
        check(chanOn[0], 1'b0);
        onQ.push_back(2'h3);
        u_dps_operator.tap(2'h1, 1);
        ticks(2);
        chCfg[0].autoRearmEn = 1'b0;
        // both-key hold refused while key edits are barred
        ratingEditEn = 1'b0;
        u_dps_operator.set_keys(2'h3);
        ticks(33);
        blink_diff();
        check({diff, led}, 16'h0011);
        u_dps_operator.set_keys(2'h0);
        ticks(2);
        ratingEditEn = 1'b1;
        // rating edit sequence with wrap of the second channel
        u_dps_operator.set_keys(2'h3);
        ticks(33);
        blink_diff();
        check(diff, 8'h11);
        u_dps_operator.set_keys(2'h0);
        ticks(2);
        check({chStat[0].rating, chStat[1].rating}, 6'h09);
        u_dps_operator.tap(2'h1, 1);
        u_dps_operator.tap(2'h2, 7);
        check({chStat[0].rating, chStat[1].rating}, 6'h14);
        u_dps_operator.set_keys(2'h3);
        ticks(33);
        check(led, 8'h00);
        u_dps_operator.set_keys(2'h0);
        ticks(2);
        check(led, 8'h82);
        // inhibit in both polarities
        inputInhibit = 1'b1;
        cyc(5);
        onQ.push_back(2'h0);
        u_dps_operator.set_remote(1'b1);
        cyc(5);
        check(statusGood, 1'b0);
        onQ.push_back(2'h3);
        u_dps_operator.set_remote(1'b0);
        cyc(5);
        onQ.push_back(2'h0);
        inhibitPolHigh = 1'b0;
        cyc(5);
        onQ.push_back(2'h3);
        inhibitPolHigh = 1'b1;
        cyc(5);
        inputInhibit = 1'b0;
        // failure on the second channel only, held after the pin clears, then failure on the first
        onQ.push_back(2'h1);
        hwFailIn = 2'h2;
        cyc(6);
        check(chStat[1].failure, 1'b1);
        blink_diff();
        check(diff[7:4] !== 4'h0, 1'b1);
        check(diff[3:0], 4'h0);
        hwFailIn = 2'h0;
        ticks(3);
        onQ.push_back(2'h0);
        hwFailIn = 2'h1;
        cyc(6);
        check({chStat[0].failure, onQ.size() == 0}, 2'h3);
        end_of_test();
    end
endmodule : dps_supervisor_test
`default_nettype wire
